// >>> src/ltc_consts.vh
/*
 * constants for the link-training control register bank: word offsets,
 * field positions, reset values and the wishbone byte addressing.
 * assumes inclusion by ltc_regs.v only; definitions only.
 */
`ifndef LTC_CONSTS_VH
`define LTC_CONSTS_VH

// printed word offsets, byte address is four times the index
`define LTC_IDX_CFG 12'h4d0
`define LTC_IDX_CMD 12'h4d1
`define LTC_IDX_STAT 12'h4d2
`define LTC_IDX_IRQ_MASK 12'h4d3
`define LTC_IDX_OVR 12'h4d4
`define LTC_ADDR_W 14

// configuration word fields
`define LTC_CFG_EN 0
`define LTC_CFG_DIS_TMR 1
`define LTC_CFG_EQ_LO 12
`define LTC_CFG_SKIP_INIT 15
`define LTC_CFG_OVR_LP 16
`define LTC_CFG_OVR_LOC 17
`define LTC_CFG_SWING 18
`define LTC_CFG_BYP_DFE 19
`define LTC_CFG_FRZ_LO 20
`define LTC_CFG_MODE 22
`define LTC_CFG_CTLE_LO 24
`define LTC_CFG_VGA_LO 29
// writable bits; 2, 3 and 23 are reserved
`define LTC_CFG_WMASK 32'hff7ffff3
`define LTC_CFG_RST_HW 32'he1105111
`define LTC_CFG_RST_SIM 32'h81585111

// command word bits, all self clearing
`define LTC_CMD_RESTART 0
`define LTC_CMD_NEW_LP 4
`define LTC_CMD_NEW_LOC 8

// status and interrupt bits
`define LTC_ST_FAIL 0
`define LTC_ST_DONE 1
`define LTC_ST_NBITS 2
`define LTC_ST_TRAINING 8
`define LTC_ST_FAILED 9

// timing
`define LTC_MAX_WAIT_NS 500000
`define LTC_CLK_NS 10

`endif

// >>> src/ltc_regs.v
/*
 * link-training control register bank with a small training sequencer.
 * holds the configuration word, decodes self-clearing command writes, drives the training engine
 * controls, tracks training progress and raises a level interrupt.
 * assumes a classic wishbone master on clk_i and an engine that reports
 * completion with a same-clock pulse.
 */
// Operation
// - error-count hysteresis from three-bit code: 0, else 2 to the code.
// - skip-initialize set keeps swing and taps on training failure.
// - max-wait timeout enters training failure and raises failure status.
// - partner override sends software update commands to the partner.
// - local override takes local coefficients from software.
// - partner main-tap swing adjusted only when swing training set.
// - bypass bit bypasses adaptive feedback equalizer after training.
// - freeze field 00 free, 01 freeze all, only while not bypassed.
// - mode 0 sweeps linear equalizer first; mode 1 uses manual values.
// - manual mode uses the five-bit linear equalizer value.
// - manual mode uses the three-bit gain value.
// - restart bit resets training protocol, then clears itself.
// - new-partner bit starts sending software values, needs override.
// - new-local bit applies software values locally, needs override.
// - training runs only while the enable bit is one.
// - disable-timer bit stops max-wait timer forcing failure.
`timescale 1ns/10ps
`include "ltc_consts.vh"

module ltc_regs #(
  parameter SIM_DEFAULTS = 0,
  parameter MAX_WAIT_CYC = `LTC_MAX_WAIT_NS / `LTC_CLK_NS
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [`LTC_ADDR_W-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire train_done_i,
  output reg irq_o,
  output reg train_active_o,
  output reg train_restart_request_o,
  output reg train_failed_o,
  output reg pma_init_o,
  output reg [7:0] err_hysteresis_o,
  output reg lp_override_o,
  output reg lp_send_o,
  output reg [7:0] lp_coef_o,
  output reg local_override_o,
  output reg local_apply_o,
  output reg [7:0] local_coef_o,
  output reg output_swing_train_o,
  output reg dfe_bypass_o,
  output reg dfe_freeze_o,
  output reg ctle_sweep_o,
  output reg [4:0] ctle_value_o,
  output reg [2:0] vga_value_o
);

  localparam [31:0] CFG_RST = SIM_DEFAULTS ? `LTC_CFG_RST_SIM : `LTC_CFG_RST_HW;
  localparam [31:0] WAIT_LAST = MAX_WAIT_CYC - 1;

  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_TRAIN = 2'b01;
  localparam [1:0] ST_DONE = 2'b10;
  localparam [1:0] ST_FAIL = 2'b11;

  // byte-lane merge, used by the configuration word only
  function [31:0] lane_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] sel;
    integer k;
    begin
      lane_merge = old_v;
      for (k = 0; k < 4; k = k + 1) begin
        if (sel[k]) begin
          lane_merge[k*8 +: 8] = new_v[k*8 +: 8];
        end
      end
    end
  endfunction

  // word-index decode shared by the write strobes and the status-read strobe
  function idx_hit;
    input [11:0] idx;
    input [11:0] target;
    begin
      idx_hit = (idx == target);
    end
  endfunction

  reg [31:0] cfg_r;
  reg [15:0] ovr_r;
  reg [`LTC_ST_NBITS-1:0] irq_stat_r;
  reg [`LTC_ST_NBITS-1:0] irq_mask_r;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [31:0] wait_cnt_r;
  reg restart_pend_r;
  reg [31:0] rd_nxt;

  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire [11:0] widx = wb_adr_i[`LTC_ADDR_W-1:2];
  wire wr = req & wb_we_i;
  wire rd = req & ~wb_we_i;
  wire wr_cfg = wr & idx_hit(widx, `LTC_IDX_CFG);
  wire wr_cmd = wr & idx_hit(widx, `LTC_IDX_CMD);
  wire wr_mask = wr & idx_hit(widx, `LTC_IDX_IRQ_MASK);
  wire wr_ovr = wr & idx_hit(widx, `LTC_IDX_OVR);
  wire rd_stat = rd & idx_hit(widx, `LTC_IDX_STAT);

  // command bits act on the write itself and never store (self clearing)
  wire cmd_restart = wr_cmd & wb_sel_i[0] & wb_dat_i[`LTC_CMD_RESTART];
  wire cmd_new_lp = wr_cmd & wb_sel_i[0] & wb_dat_i[`LTC_CMD_NEW_LP];
  wire cmd_new_loc = wr_cmd & wb_sel_i[1] & wb_dat_i[`LTC_CMD_NEW_LOC];

  wire enabled = cfg_r[`LTC_CFG_EN];
  wire timed_out = ~cfg_r[`LTC_CFG_DIS_TMR] & (wait_cnt_r == WAIT_LAST);
  // no event while training is being switched off, so no stray status
  wire ev_fail = (state_r == ST_TRAIN) & enabled & timed_out & ~train_done_i & ~restart_pend_r;
  wire ev_done = (state_r == ST_TRAIN) & enabled & train_done_i & ~restart_pend_r;

  // wishbone slave: one registered ack per request, a cycle later, unmapped reads zero
  always @* begin
    rd_nxt = 32'h00000000;
    case (widx)
      `LTC_IDX_CFG: rd_nxt = cfg_r;
      `LTC_IDX_STAT: rd_nxt = {22'h000000, state_r == ST_FAIL, state_r == ST_TRAIN,
                               6'h00, irq_stat_r};
      `LTC_IDX_IRQ_MASK: rd_nxt = {30'h00000000, irq_mask_r};
      `LTC_IDX_OVR: rd_nxt = {8'h00, ovr_r[15:8], 8'h00, ovr_r[7:0]};
      default: rd_nxt = 32'h00000000;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= rd ? rd_nxt : 32'h00000000;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      cfg_r <= CFG_RST;
    end else if (wr_cfg) begin
      cfg_r <= lane_merge(cfg_r, wb_dat_i, wb_sel_i) & `LTC_CFG_WMASK;
    end
  end

  // coefficient word keeps only the two byte lanes the engine uses
  always @(posedge clk_i) begin
    if (rst_i) begin
      ovr_r <= 16'h0000;
    end else if (wr_ovr) begin
      ovr_r[7:0] <= wb_sel_i[0] ? wb_dat_i[7:0] : ovr_r[7:0];
      ovr_r[15:8] <= wb_sel_i[2] ? wb_dat_i[23:16] : ovr_r[15:8];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_r <= {`LTC_ST_NBITS{1'b0}};
    end else if (wr_mask & wb_sel_i[0]) begin
      irq_mask_r <= wb_dat_i[`LTC_ST_NBITS-1:0];
    end
  end

  // sticky events; a new event in the read cycle survives the clear
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_r <= {`LTC_ST_NBITS{1'b0}};
    end else begin
      irq_stat_r[`LTC_ST_FAIL] <= ev_fail | (irq_stat_r[`LTC_ST_FAIL] & ~rd_stat);
      irq_stat_r[`LTC_ST_DONE] <= ev_done | (irq_stat_r[`LTC_ST_DONE] & ~rd_stat);
    end
  end

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (enabled) state_nxt = ST_TRAIN;
      ST_TRAIN: begin
        if (!enabled) state_nxt = ST_IDLE;
        else if (ev_done) state_nxt = ST_DONE;
        else if (ev_fail) state_nxt = ST_FAIL;
      end
      ST_DONE: if (!enabled) state_nxt = ST_IDLE;
      ST_FAIL: if (!enabled) state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
    if (restart_pend_r) begin
      state_nxt = ST_IDLE;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // restart acts one cycle after the write so the ack and idle entry stay apart
  always @(posedge clk_i) begin
    if (rst_i) begin
      restart_pend_r <= 1'b0;
    end else begin
      restart_pend_r <= cmd_restart;
    end
  end

  // counter saturates; clearing the disable bit late in training fails at once
  always @(posedge clk_i) begin
    if (rst_i) begin
      wait_cnt_r <= 32'h00000000;
    end else if (state_r != ST_TRAIN || restart_pend_r) begin
      wait_cnt_r <= 32'h00000000;
    end else if (wait_cnt_r != WAIT_LAST) begin
      wait_cnt_r <= wait_cnt_r + 32'h00000001;
    end
  end

  // engine-facing controls, each its own flip-flop stage
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_r & irq_mask_r);
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      train_active_o <= 1'b0;
    end else begin
      train_active_o <= (state_r == ST_TRAIN);
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      train_restart_request_o <= 1'b0;
    end else begin
      train_restart_request_o <= cmd_restart;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      train_failed_o <= 1'b0;
    end else begin
      train_failed_o <= (state_nxt == ST_FAIL);
    end
  end

  // one-cycle reinit pulse on failure entry unless skipped
  always @(posedge clk_i) begin
    if (rst_i) begin
      pma_init_o <= 1'b0;
    end else begin
      pma_init_o <= ev_fail & (state_nxt == ST_FAIL) & ~cfg_r[`LTC_CFG_SKIP_INIT];
    end
  end

  // code 0 gives 0, otherwise 1 shifted by the code
  always @(posedge clk_i) begin
    if (rst_i) begin
      err_hysteresis_o <= 8'h00;
    end else begin
      err_hysteresis_o <= (cfg_r[`LTC_CFG_EQ_LO +: 3] == 3'h0) ? 8'h00 :
                          (8'h01 << cfg_r[`LTC_CFG_EQ_LO +: 3]);
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      lp_override_o <= 1'b0;
    end else begin
      lp_override_o <= cfg_r[`LTC_CFG_OVR_LP];
    end
  end

  // a send request without the override is dropped, not queued
  always @(posedge clk_i) begin
    if (rst_i) begin
      lp_send_o <= 1'b0;
    end else begin
      lp_send_o <= cmd_new_lp & cfg_r[`LTC_CFG_OVR_LP];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      lp_coef_o <= 8'h00;
    end else begin
      lp_coef_o <= ovr_r[7:0];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      local_override_o <= 1'b0;
    end else begin
      local_override_o <= cfg_r[`LTC_CFG_OVR_LOC];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      local_apply_o <= 1'b0;
    end else begin
      local_apply_o <= cmd_new_loc & cfg_r[`LTC_CFG_OVR_LOC];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      local_coef_o <= 8'h00;
    end else begin
      local_coef_o <= ovr_r[15:8];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      output_swing_train_o <= 1'b0;
    end else begin
      output_swing_train_o <= cfg_r[`LTC_CFG_SWING];
    end
  end

  // bypass and freeze only take hold in the done state, not after a training failure
  always @(posedge clk_i) begin
    if (rst_i) begin
      dfe_bypass_o <= 1'b0;
    end else begin
      dfe_bypass_o <= (state_r == ST_DONE) & cfg_r[`LTC_CFG_BYP_DFE];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      dfe_freeze_o <= 1'b0;
    end else begin
      dfe_freeze_o <= (state_r == ST_DONE) & ~cfg_r[`LTC_CFG_BYP_DFE] &
                      (cfg_r[`LTC_CFG_FRZ_LO +: 2] == 2'b01);
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ctle_sweep_o <= 1'b0;
    end else begin
      ctle_sweep_o <= ~cfg_r[`LTC_CFG_MODE];
    end
  end

  // manual values forced to zero in sweep mode
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctle_value_o <= 5'h00;
    end else begin
      ctle_value_o <= cfg_r[`LTC_CFG_MODE] ? cfg_r[`LTC_CFG_CTLE_LO +: 5] : 5'h00;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      vga_value_o <= 3'h0;
    end else begin
      vga_value_o <= cfg_r[`LTC_CFG_MODE] ? cfg_r[`LTC_CFG_VGA_LO +: 3] : 3'h0;
    end
  end

endmodule

// >>> tb/ltc_engine_model.sv
/* training engine stand-in: done pulse after a delay, or silence.
   assumes train_active_i from ltc_regs on the same clock. */
`timescale 1ns/10ps
module ltc_engine_model (
  input wire clk_i,
  input wire rst_i,
  input wire train_active_i,
  input wire answer_i,
  input wire [3:0] delay_i,
  output reg train_done_o
);
  reg [3:0] cnt_r;
  always @(posedge clk_i) begin
    if (rst_i || !train_active_i) begin
      cnt_r <= 4'h0;
      train_done_o <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
      train_done_o <= answer_i && cnt_r == delay_i;
    end
  end
endmodule

// >>> tb/ltc_regs_assertions.sv
/* port checker for ltc_regs, bound below.
   assumes sel 4'hf on configuration writes. */
`timescale 1ns/10ps
module ltc_regs_chk (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [13:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire wb_ack_o,
  input wire train_restart_request_o,
  input wire train_failed_o,
  input wire pma_init_o,
  input wire [7:0] err_hysteresis_o,
  input wire lp_override_o,
  input wire lp_send_o,
  input wire output_swing_train_o,
  input wire dfe_bypass_o,
  input wire dfe_freeze_o
);
  reg [31:0] cfg_d;
  wire [7:0] hyst_w = (cfg_d[14:12] == 3'h0) ? 8'h00 : 8'h01 << cfg_d[14:12];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence cfg_wr_s;
    req_s ##0 (wb_we_i && wb_adr_i == 14'h1340 && wb_sel_i == 4'hf);
  endsequence
  sequence cmd_wr_s;
    req_s ##0 (wb_we_i && wb_adr_i == 14'h1344 && wb_sel_i[0]);
  endsequence
  always @(posedge clk_i) begin
    if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == 14'h1340) begin
      cfg_d <= wb_dat_i;
    end
  end
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  ack_next_a: assert property (req_s |=> wb_ack_o) else $error("no ack");
  hyst_code_a: assert property (cfg_wr_s |-> ##2 err_hysteresis_o == hyst_w)
    else $error("hysteresis wrong");
  cfg_copy_a: assert property (cfg_wr_s |-> ##2
    lp_override_o == cfg_d[16] && output_swing_train_o == cfg_d[18]) else $error("copy wrong");
  restart_pulse_a: assert property (cmd_wr_s ##0 wb_dat_i[0] |=>
    train_restart_request_o ##1 !train_restart_request_o) else $error("restart pulse");
  lp_send_a: assert property (cmd_wr_s ##0 wb_dat_i[4] |=>
    lp_send_o == lp_override_o) else $error("send wrong");
  dfe_excl_a: assert property (dfe_freeze_o |-> !dfe_bypass_o) else $error("dfe both");
  pma_pulse_a: assert property (pma_init_o |=> !pma_init_o && train_failed_o)
    else $error("pma pulse");
endmodule
bind ltc_regs ltc_regs_chk i_ltc_regs_chk (.*);

// >>> tb/ltc_regs_tb.sv
/* bench for ltc_regs: wishbone master, engine model, bound checker.
   assumes 100 MHz clk_i and sync active-high reset. */
`timescale 1ns/10ps
module ltc_regs_tb;
  localparam MW = 20;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg cyc = 1'b0;
  reg we = 1'b0;
  reg ans = 1'b0;
  reg [13:0] adr = 14'h0000;
  reg [31:0] dat = 32'h0;
  reg [31:0] v, r;
  wire [31:0] q;
  wire [7:0] hys, lpc, lcc;
  wire [4:0] ctl;
  wire [2:0] vga;
  wire ack, irq, act, rsq, fl, pma, lpo, lps, lco, lca, swg, byp, frz, swp, dn;
  integer bad_count = 0, checks = 0, npma = 0, nsend = 0, i, n0;
  ltc_regs #(.SIM_DEFAULTS(0), .MAX_WAIT_CYC(MW)) i_ltc_regs (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(dat), .wb_dat_o(q), .wb_ack_o(ack), .train_done_i(dn), .irq_o(irq),
    .train_active_o(act), .train_restart_request_o(rsq), .train_failed_o(fl),
    .pma_init_o(pma), .err_hysteresis_o(hys), .lp_override_o(lpo), .lp_send_o(lps),
    .lp_coef_o(lpc), .local_override_o(lco), .local_apply_o(lca), .local_coef_o(lcc),
    .output_swing_train_o(swg), .dfe_bypass_o(byp), .dfe_freeze_o(frz),
    .ctle_sweep_o(swp), .ctle_value_o(ctl), .vga_value_o(vga));
  ltc_engine_model i_ltc_engine_model (.clk_i(clk_i), .rst_i(rst_i), .train_active_i(act),
    .answer_i(ans), .delay_i(4'h3), .train_done_o(dn));
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    npma = npma + pma;
    nsend = nsend + {lps, 4'h0} + lca;
  end
  function [7:0] hyst(input [2:0] c);
    hyst = (c == 3'h0) ? 8'h00 : 8'h01 << c;
  endfunction
  task print_verdict;
    begin
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      checks = checks + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  // call only just after a rising edge; v gets the read data
  task wb(input w, input [13:0] a, input [31:0] d);
    integer n;
    begin
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      n = 0;
      @(posedge clk_i);
      while (ack !== 1'b1) begin
        n = n + 1;
        if (n > 40) begin
          bad_count = bad_count + 1;
          print_verdict;
        end
        @(posedge clk_i);
      end
      v = q;
      cyc <= 1'b0;
      we <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  initial begin
    v = $urandom(30);
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(0, 14'h1340, 0);
    chk(v, 32'he1105111);
    wb(0, 14'h1344, 0);
    chk(v, 0);
    wb(0, 14'h1400, 0);
    chk(v, 0);
    for (i = 0; i < 8; i = i + 1) begin
      r = $urandom;
      r[14:12] = i[2:0];
      r[1:0] = 2'b01;
      wb(1, 14'h1340, r);
      wb(0, 14'h1340, 0);
      chk(v, r & 32'hff7ffff3);
      chk(hys, hyst(i[2:0]));
      chk({swg, lpo, lco, swp}, {r[18], r[16], r[17], ~r[22]});
      chk({vga, ctl}, r[22] ? r[31:24] : 8'h00);
    end
    for (i = 0; i < 2; i = i + 1) begin
      wb(1, 14'h134c, {31'h0, ~i[0]});
      wb(1, 14'h1340, {16'h0, i[0], 15'h1});
      n0 = npma;
      wb(1, 14'h1344, 32'h1);
      repeat (MW - 6) @(posedge clk_i);
      chk(fl, 0);
      repeat (14) @(posedge clk_i);
      chk({fl, irq}, {1'b1, ~i[0]});
      chk(npma - n0, 1 - i);
      wb(1, 14'h134c, 32'h1);
      chk(irq, 1);
      wb(0, 14'h1348, 0);
      chk({irq, v}, 32'h201);
    end
    wb(1, 14'h1340, 32'h3);
    wb(1, 14'h1344, 32'h1);
    repeat (3 * MW) @(posedge clk_i);
    chk({act, fl}, 2'b10);
    wb(1, 14'h1340, 0);
    wb(1, 14'h1344, 32'h1);
    repeat (10) @(posedge clk_i);
    chk({act, fl}, 0);
    ans <= 1'b1;
    for (i = 0; i < 4; i = i + 1) begin
      wb(1, 14'h1340, i == 0 ? 32'h00180001 : 32'h1 | (i << 20));
      wb(1, 14'h1344, 32'h1);
      repeat (20) @(posedge clk_i);
      chk({byp, frz}, {i == 0, i == 1});
      wb(0, 14'h1348, 0);
      chk(v, 32'h2);
    end
    r = $urandom;
    wb(1, 14'h1350, r);
    for (i = 0; i < 2; i = i + 1) begin
      wb(1, 14'h1340, {14'h0, ~i[0], ~i[0], 16'h1});
      n0 = nsend;
      wb(1, 14'h1344, 32'h110);
      @(posedge clk_i);
      chk(nsend - n0, i ? 0 : 17);
    end
    chk({lcc, lpc}, {r[23:16], r[7:0]});
    print_verdict;
  end
endmodule
